// file: mem_err_log_pkg.sv
// constants, field layout and carrier types for the memory error logging bank block
package mem_err_log_pkg;
  // bank numbering and bank split between the two controllers
  localparam int BANKS_PER_CTRL = 4;
  localparam int NUM_BANKS      = 2 * BANKS_PER_CTRL;
  localparam int FIRST_BANK_NUM = 9;  // first controller owns banks 9..12, second 13..16
  // bus geometry
  localparam int ADR_W = 8;
  localparam int DAT_W = 32;
  // register map: each bank takes four words (status lo/hi, detail lo/hi)
  localparam logic [7:0] BANK_SPAN_OFS   = 8'h10;
  localparam logic [1:0] WORD_STATUS_LO  = 2'h0;
  localparam logic [1:0] WORD_STATUS_HI  = 2'h1;
  localparam logic [1:0] WORD_DETAIL_LO  = 2'h2;
  localparam logic [1:0] WORD_DETAIL_HI  = 2'h3;
  localparam logic [7:0] BANK_AREA_END   = 8'h80;
  localparam logic [7:0] CTRL_OFS        = 8'h80;  // extra_logging_control
  localparam logic [7:0] IRQ_STATUS_OFS  = 8'h84;
  localparam logic [7:0] IRQ_MASK_OFS    = 8'h88;
  localparam int         CTRL_EXTRA_BIT  = 1;
  localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
  // architectural error code pattern 000F 0000 1MMM CCCC
  localparam logic [15:0] ARCH_MEM_MARK  = 16'h0080;
  // model-specific error codes, status bits 31:16
  localparam logic [15:0] MSC_ADDR_PARITY      = 16'h0001;
  localparam logic [15:0] MSC_HA_WR_DATA_PAR   = 16'h0002;
  localparam logic [15:0] MSC_HA_WR_BE_PAR     = 16'h0004;
  localparam logic [15:0] MSC_SCRUB_CORR       = 16'h0008;
  localparam logic [15:0] MSC_SCRUB_UNCORR     = 16'h0010;
  localparam logic [15:0] MSC_SPARE_CORR       = 16'h0020;
  localparam logic [15:0] MSC_SPARE_UNCORR     = 16'h0040;
  localparam logic [15:0] MSC_READ_CORR        = 16'h0080;
  localparam logic [15:0] MSC_BUFFER_PARITY    = 16'h0100;
  // detail register field positions
  localparam int DET_BUF_LSB   = 9;
  localparam int DET_MASK1_LSB = 14;
  localparam int DET_MASK2_LSB = 30;
  localparam int DET_RANK1_LSB = 46;
  localparam int DET_RANK2_LSB = 51;
  localparam int DET_VALID1    = 62;
  localparam int DET_VALID2    = 63;
  localparam int STS_DEV_LSB   = 32;  // status 36:32, bit 37 reserved
  // error causes reported by the controllers
  typedef enum logic [3:0] {
    CAUSE_ADDR_PARITY, CAUSE_HOME_AGENT_WR_DATA, CAUSE_HOME_AGENT_WR_BE,
    CAUSE_SCRUB_CORR, CAUSE_SCRUB_UNCORR, CAUSE_SPARE_CORR, CAUSE_SPARE_UNCORR,
    CAUSE_READ_CORR, CAUSE_BUFFER_PARITY
  } errCause_e;
  // one error report from a controller
  typedef struct packed {
    logic        valid;
    logic        ctrlSel;     // 0 first controller, 1 second
    logic [1:0]  bankInCtrl;
    errCause_e   cause;
    logic [2:0]  txnType;     // MMM
    logic [3:0]  channel;     // CCCC
    logic [4:0]  deviceCode;
    logic [15:0] bitMask;
    logic [4:0]  rank;
    logic [4:0]  bufferId;
  } errEvent_s;
  // classic wishbone request from the master
  typedef struct packed {
    logic             cyc;
    logic             stb;
    logic             we;
    logic [ADR_W-1:0] adr;
    logic [3:0]       sel;
    logic [DAT_W-1:0] dat;
  } wbReq_s;
endpackage : mem_err_log_pkg

// file: memory_ctrl_error_logging.sv
// memory controller error logging banks with wishbone register access and interrupt
//
// Local design decisions: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// How it works
// - controller one banks 9-12, two 13-16
// - status 15:0 holds 1MMM CCCC code
// - codes 001H, 002H, 004H for parity faults
// - patrol scrub: corrected 008H, uncorrected 010H
// - spare: corrected 020H, uncorrected 040H
// - corrected read 080H only with extra logging
// - write buffer parity reports code 100H
// - control bit 1 enables extra detail
// - status 36:32 first device code, 37 reserved
// - detail 13:9 buffer id or second device
// - detail bit masks 29:14 and 45:30
// - detail ranks 50:46 and 55:51
// - detail bit 62 first device valid
// - detail bit 63 second valid, after first
module memory_ctrl_error_logging
  import mem_err_log_pkg::*;
#(
  parameter int NBANK = NUM_BANKS
) (
  input  wire logic             clk_sys,   // 25 MHz system clock
  input  wire logic             rst_n,     // synchronous, active low
  input  wire errEvent_s        errEvent,  // error report, same clock domain
  input  wire wbReq_s           wbReq,     // wishbone request
  output logic                  wbAck,     // wishbone acknowledge
  output logic [DAT_W-1:0]      wbDatOut,  // wishbone read data
  output logic                  irq        // level interrupt
);

  // model-specific code for a cause
  // an unknown cause gives zero, so a corrupt report still logs its pattern
  function automatic logic [15:0] msCodeOf(input errCause_e c);
    case (c)
      CAUSE_ADDR_PARITY:        msCodeOf = MSC_ADDR_PARITY;
      CAUSE_HOME_AGENT_WR_DATA: msCodeOf = MSC_HA_WR_DATA_PAR;
      CAUSE_HOME_AGENT_WR_BE:   msCodeOf = MSC_HA_WR_BE_PAR;
      CAUSE_SCRUB_CORR:         msCodeOf = MSC_SCRUB_CORR;
      CAUSE_SCRUB_UNCORR:       msCodeOf = MSC_SCRUB_UNCORR;
      CAUSE_SPARE_CORR:         msCodeOf = MSC_SPARE_CORR;
      CAUSE_SPARE_UNCORR:       msCodeOf = MSC_SPARE_UNCORR;
      CAUSE_READ_CORR:          msCodeOf = MSC_READ_CORR;
      CAUSE_BUFFER_PARITY:      msCodeOf = MSC_BUFFER_PARITY;
      default:                  msCodeOf = 16'h0000;
    endcase
  endfunction : msCodeOf

  // byte-lane merge of a write into a word
  // lanes whose select is low keep their old contents
  function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] wr,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = wr[8*i +: 8];
      end
    end
    laneMerge = r;
  endfunction : laneMerge

  // ---- bus decode ----
  // register map, byte addresses:
  //   bank index i (bank number 9+i) at 0x10*i: +0 status low, +4 status high,
  //   +8 detail low, +C detail high
  //   0x80 extra_logging_control, 0x84 interrupt status, 0x88 interrupt mask
  // every access, mapped or not, is acknowledged after one wait state, so a
  // master never hangs on a stray address; the price is that software gets no
  // error response for a wrong address
  logic              ackR;                   // registered acknowledge
  logic [DAT_W-1:0]  rdDataR;                // registered read data
  wire               busReq   = wbReq.cyc & wbReq.stb;
  wire               wrCommit = busReq & wbReq.we & ackR;  // write lands on the ack edge
  wire [2:0]         adrBank  = wbReq.adr[6:4];
  wire [1:0]         adrWord  = wbReq.adr[3:2];
  wire               inBanks  = (wbReq.adr < BANK_AREA_END);
  wire               hitCtrl  = (wbReq.adr == CTRL_OFS);
  wire               hitIrqSt = (wbReq.adr == IRQ_STATUS_OFS);
  wire               hitIrqMk = (wbReq.adr == IRQ_MASK_OFS);
  // writing the status low word of a bank clears that bank for the next error
  wire               bankClrHit = wrCommit & inBanks & (adrWord == WORD_STATUS_LO)
                                  & (wbReq.sel != 4'h0);

  // ---- software registers ----
  // only bit 1 of the control word acts; the other bits are kept so that
  // software reads back what it wrote
  logic [31:0]       ctrlR;                  // extra_logging_control
  logic [NBANK-1:0]  irqStatR;               // sticky per-bank logged events
  logic [NBANK-1:0]  irqMaskR;               // per-bank interrupt enables
  wire               extraOn = ctrlR[CTRL_EXTRA_BIT];

  // ---- event routing ----
  // a report is taken in the cycle its valid bit is high; there is no queue,
  // the controllers send at most one report per cycle
  // banks 0..3 here are bank numbers 9..12, 4..7 are 13..16
  wire [2:0]  evtBank = {errEvent.ctrlSel, errEvent.bankInCtrl};
  // corrected read errors are only reported while extra logging is on
  wire        evtTake = errEvent.valid & ((errEvent.cause != CAUSE_READ_CORR) | extraOn);
  wire [15:0] evtArch = ARCH_MEM_MARK | {9'h000, errEvent.txnType, errEvent.channel};
  wire [15:0] evtMsc  = msCodeOf(errEvent.cause);
  wire        evtIsRd = (errEvent.cause == CAUSE_READ_CORR);
  // parity faults on buffered writes carry the buffer identifier
  wire        evtBufId = (errEvent.cause == CAUSE_HOME_AGENT_WR_DATA)
                         | (errEvent.cause == CAUSE_HOME_AGENT_WR_BE)
                         | (errEvent.cause == CAUSE_BUFFER_PARITY);

  // ---- bank storage ----
  // each bank keeps the first report and, in extra mode, one follow-up
  // corrected read; anything later is dropped until software clears the bank,
  // so the log shows the oldest error rather than the newest
  logic [15:0] archR  [NBANK];  // architectural_error_code
  logic [15:0] mscR   [NBANK];  // model-specific cause
  logic [4:0]  devR   [NBANK];  // first failing device code
  logic [4:0]  bufR   [NBANK];  // buffer id or second device
  logic [15:0] mask1R [NBANK];  // first_device_bit_mask
  logic [15:0] mask2R [NBANK];  // second_device_bit_mask
  logic [4:0]  rank1R [NBANK];  // first_device_failing_rank
  logic [4:0]  rank2R [NBANK];  // second_device_failing_rank
  logic        val1R  [NBANK];  // first_device_info_valid
  logic        val2R  [NBANK];  // second_device_info_valid
  logic        usedR  [NBANK];  // bank holds an error
  logic [63:0] stsWord [NBANK]; // assembled bank_error_status
  logic [63:0] detWord [NBANK]; // assembled bank_error_detail
  logic [NBANK-1:0] firstCap;   // first error captured this cycle

  genvar b;
  generate
    for (b = 0; b < NBANK; b++) begin : g_bank
      wire hit   = evtTake & (evtBank == 3'(b));
      wire clr   = bankClrHit & (adrBank == 3'(b));
      // clearing and a new error together: the error wins and refills the bank
      wire first = hit & (~usedR[b] | clr);
      // a second corrected read fills the second-device slot once
      wire second = hit & ~first & evtIsRd & extraOn & val1R[b] & ~val2R[b];
      assign firstCap[b] = first;

      // bank capture; later errors beyond the second are not logged
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          usedR[b]  <= 1'b0;
          archR[b]  <= 16'h0000;
          mscR[b]   <= 16'h0000;
          bufR[b]   <= 5'h00;
        end else if (first) begin
          usedR[b]  <= 1'b1;
          archR[b]  <= evtArch;
          mscR[b]   <= evtMsc;
          bufR[b]   <= evtBufId ? errEvent.bufferId : 5'h00;
        end else if (second) begin
          bufR[b]   <= errEvent.deviceCode;
        end else if (clr) begin
          usedR[b]  <= 1'b0;
          archR[b]  <= 16'h0000;
          mscR[b]   <= 16'h0000;
          bufR[b]   <= 5'h00;
        end
      end

      // extra detail fields, forced clear whenever extra logging is off
      // clearing every cycle while off means stale detail in these fields can never
      // reappear once logging is switched on again; a second device code held in bufR stays
      always_ff @(posedge clk_sys) begin
        if (!rst_n || !extraOn || (clr && !first)) begin
          devR[b]   <= 5'h00;
          mask1R[b] <= 16'h0000;
          rank1R[b] <= 5'h00;
          val1R[b]  <= 1'b0;
          mask2R[b] <= 16'h0000;
          rank2R[b] <= 5'h00;
          val2R[b]  <= 1'b0;
        end else if (first) begin
          devR[b]   <= errEvent.deviceCode;
          mask1R[b] <= errEvent.bitMask;
          rank1R[b] <= errEvent.rank;
          val1R[b]  <= evtIsRd;
          mask2R[b] <= 16'h0000;
          rank2R[b] <= 5'h00;
          val2R[b]  <= 1'b0;
        end else if (second) begin
          mask2R[b] <= errEvent.bitMask;
          rank2R[b] <= errEvent.rank;
          val2R[b]  <= 1'b1;
        end
      end

      // register images; bit 37 and the architectural upper fields read zero
      assign stsWord[b] = {27'h0000000, devR[b], mscR[b], archR[b]};
      assign detWord[b] = {val2R[b], val1R[b], 6'h00, rank2R[b], rank1R[b],
                           mask2R[b], mask1R[b], bufR[b], 9'h000};
    end
  endgenerate

  // ---- control, interrupt status and mask ----
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrlR    <= CTRL_RESET;
      irqMaskR <= '0;
    end else if (wrCommit) begin
      if (hitCtrl) begin
        ctrlR <= laneMerge(ctrlR, wbReq.dat, wbReq.sel);
      end
      if (hitIrqMk) begin
        irqMaskR <= NBANK'(laneMerge(32'(irqMaskR), wbReq.dat, wbReq.sel));
      end
    end
  end

  // write one to clear; a capture in the same cycle keeps its bit set
  // only a first capture sets a bit: a second-device fill adds detail to an
  // error already signalled and raises nothing new
  wire [NBANK-1:0] irqW1c = (wrCommit & hitIrqSt & wbReq.sel[0]) ? wbReq.dat[NBANK-1:0] : '0;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      irqStatR <= '0;
    end else begin
      irqStatR <= (irqStatR & ~irqW1c) | firstCap;
    end
  end

  assign irq = |(irqStatR & irqMaskR);

  // ---- read path ----
  // the mux is combinational from registers; its result is caught in rdDataR
  // on the request edge, so a capture one cycle later is not seen by a read
  // already in flight
  wire [63:0] selSts  = stsWord[adrBank];
  wire [63:0] selDet  = detWord[adrBank];
  wire [31:0] bankRd  = (adrWord == WORD_STATUS_LO) ? selSts[31:0]  :
                        (adrWord == WORD_STATUS_HI) ? selSts[63:32] :
                        (adrWord == WORD_DETAIL_LO) ? selDet[31:0]  : selDet[63:32];
  // unmapped addresses read zero and are acknowledged
  wire [31:0] readMux = inBanks  ? bankRd :
                        hitCtrl  ? ctrlR  :
                        hitIrqSt ? 32'(irqStatR) :
                        hitIrqMk ? 32'(irqMaskR) : 32'h0000_0000;

  // one wait state: data is sampled on the request edge, ack follows
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ackR    <= 1'b0;
      rdDataR <= '0;
    end else begin
      ackR <= busReq & ~ackR;
      if (busReq & ~ackR) begin
        rdDataR <= readMux;
      end
    end
  end

  assign wbAck    = ackR;
  assign wbDatOut = rdDataR;

  // ---- assertions ----
  // all checks run on the system clock and are off during reset, except the
  // reset check itself; most watch one fixed bank so that the properties stay
  // small and the bench reaches their antecedents
  sequence s_first_rd(int k);
    evtTake && evtIsRd && (evtBank == 3'(k)) && !usedR[k] && extraOn;
  endsequence

  sequence s_req_then_ack;
    busReq && !ackR ##1 ackR;
  endsequence

  // second controller reports other than corrected reads never land in first controller banks
  a_bank_route: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (errEvent.valid && errEvent.ctrlSel && errEvent.cause != CAUSE_READ_CORR)
      |-> (firstCap[3:0] == 4'h0))
    else $error("second controller event touched a first controller bank");

  // stored code keeps the leading one and the MMM CCCC fields
  a_arch_format: assert property (@(posedge clk_sys) disable iff (!rst_n)
    firstCap[0] |=> (archR[0][15:7] == 9'h001) && (archR[0][6:0] == $past(evtArch[6:0])))
    else $error("architectural code not in memory pattern");

  // with extra logging off a corrected read leaves every bank alone
  a_read_dropped: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (errEvent.valid && evtIsRd && !extraOn) |-> (firstCap == '0))
    else $error("corrected read logged while extra logging off");

  // uncorrected scrub into bank index 4, where the bench routes it
  a_scrub_code: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (firstCap[4] && errEvent.cause == CAUSE_SCRUB_UNCORR) |=> (mscR[4] == MSC_SCRUB_UNCORR))
    else $error("uncorrected scrub code wrong");

  // first corrected read in extra mode marks the first device valid
  a_first_valid: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_first_rd(0) ##1 extraOn |-> val1R[0] && stsWord[0][36:32] == $past(errEvent.deviceCode))
    else $error("first device data not captured");

  // second device valid never stands without the first
  a_second_order: assert property (@(posedge clk_sys) disable iff (!rst_n)
    val2R[0] |-> val1R[0])
    else $error("second device valid without first");

  // one cycle after logging is switched off the extra fields are gone
  a_extra_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !extraOn ##1 !extraOn |-> (detWord[0][63:14] == '0) && (stsWord[0][37:32] == '0))
    else $error("extra fields set while disabled");

  // acknowledge is a single pulse
  a_bus_ack: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_req_then_ack |=> !ackR)
    else $error("ack held longer than one cycle");

  // a first capture always raises its pending bit
  a_irq_sticky: assert property (@(posedge clk_sys) disable iff (!rst_n)
    firstCap[1] |=> irqStatR[1])
    else $error("capture did not set interrupt status");

  // second corrected read into a used bank, no clear in the same cycle
  sequence s_second_rd(int k);
    evtTake && evtIsRd && (evtBank == 3'(k)) && usedR[k] && val1R[k] && !val2R[k]
      && extraOn && !bankClrHit;
  endsequence

  // any report aimed at a bank whose second slot is already full
  sequence s_late_report(int k);
    evtTake && (evtBank == 3'(k)) && usedR[k] && val2R[k] && !bankClrHit;
  endsequence

  // a bus request always gets its acknowledge on the next edge
  a_bus_answer: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (busReq && !ackR) |=> ackR)
    else $error("request not acknowledged after one wait state");

  // reset leaves no acknowledge and no interrupt behind
  a_reset_quiet: assert property (@(posedge clk_sys)
    !rst_n |=> !ackR && !irq && (irqStatR == '0))
    else $error("outputs not quiet after reset");

  // parity fault on a home agent write carries its code and buffer id
  a_parity_code: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (firstCap[1] && errEvent.cause == CAUSE_HOME_AGENT_WR_DATA)
      |=> (mscR[1] == MSC_HA_WR_DATA_PAR) && (bufR[1] == $past(errEvent.bufferId)))
    else $error("write data parity code or buffer id wrong");

  a_spare_code: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (firstCap[5] && errEvent.cause == CAUSE_SPARE_CORR) |=> (mscR[5] == MSC_SPARE_CORR))
    else $error("corrected spare code wrong");

  a_buffer_code: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (firstCap[7] && errEvent.cause == CAUSE_BUFFER_PARITY)
      |=> (mscR[7] == MSC_BUFFER_PARITY))
    else $error("write buffer parity code wrong");

  // the enable bit follows the last control write
  a_ctrl_enable: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (wrCommit && hitCtrl && wbReq.sel[0])
      |=> (extraOn == $past(wbReq.dat[CTRL_EXTRA_BIT])))
    else $error("extra logging enable not taken from control write");

  // first corrected read stores mask and rank of the first device
  a_first_fields: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_first_rd(0) |=> (detWord[0][DET_MASK1_LSB +: 16] == $past(errEvent.bitMask))
                      && (detWord[0][DET_RANK1_LSB +: 5] == $past(errEvent.rank)))
    else $error("first device mask or rank not captured");

  // second corrected read fills the second device slot
  a_second_fill: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_second_rd(0) |=> val2R[0] && (detWord[0][DET_BUF_LSB +: 5] == $past(errEvent.deviceCode))
                       && (detWord[0][DET_MASK2_LSB +: 16] == $past(errEvent.bitMask))
                       && (detWord[0][DET_RANK2_LSB +: 5] == $past(errEvent.rank)))
    else $error("second device slot not filled");

  // reports beyond the second leave the bank untouched
  a_third_ignored: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_late_report(0) |=> $stable(stsWord[0][31:0]) && $stable(detWord[0][13:9]))
    else $error("full bank overwritten by a later report");

  // write one to clear drops a pending bit when no capture competes
  a_irq_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (irqW1c[3] && !firstCap[3]) |=> !irqStatR[3])
    else $error("interrupt status bit not cleared by write one");

endmodule : memory_ctrl_error_logging

// file: memory_ctrl_error_logging_tb_top.sv
// self-checking bench for the memory error logging banks
`timescale 1ns/1ps
module memory_ctrl_error_logging_tb_top;
  import mem_err_log_pkg::*;
  // one expected bus answer, kept in request order
  typedef struct {string nm; logic [31:0] exp; bit chk;} note_s;
  logic             clk_sys;   // 25 MHz system clock
  logic             rst_n;     // synchronous, active low
  errEvent_s        errEvent;  // error report driven by the bench
  wbReq_s           wbReq;     // bus request driven by the bench
  logic             wbAck;     // bus acknowledge
  logic [DAT_W-1:0] wbDatOut;  // bus read data
  logic             irq;       // level interrupt
  note_s            notes[$];  // pending expectations
  note_s            mon;       // note taken by the watcher
  int               n_fail;    // mismatch count
  int               n_tests;   // comparison count

  memory_ctrl_error_logging #(.NBANK(NUM_BANKS)) u_memory_ctrl_error_logging (
    .clk_sys(clk_sys), .rst_n(rst_n), .errEvent(errEvent), .wbReq(wbReq),
    .wbAck(wbAck), .wbDatOut(wbDatOut), .irq(irq));

  // free running clock, 40 ns period
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // one comparison, counted, reported at once on a miss
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // verdict and end of run
  task automatic tally_and_finish();
    if (n_fail == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish

  // classic single cycle; request held until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                    input string nm, input logic [31:0] exp, input bit chk);
    note_s n;
    int    k;
    n = '{nm, exp, chk};
    notes.push_back(n);
    @(posedge clk_sys);
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: dat};
    for (k = 0; k < 20; k++) begin
      @(posedge clk_sys);
      if (wbAck === 1'b1) break;
    end
    wbReq <= '0;  // release only after the ack edge
    if (k == 20) begin
      n_fail++;
      tally_and_finish();
    end
  endtask : wb

  // read with expectation, write without
  task automatic rd(input logic [7:0] adr, input string nm, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0000_0000, nm, exp, 1'b1);
  endtask : rd
  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    wb(1'b1, adr, dat, "write", 32'h0000_0000, 1'b0);
  endtask : wr

  // one-cycle error report pulse
  task automatic send(input errEvent_s e);
    @(posedge clk_sys);
    errEvent <= e;
    @(posedge clk_sys);
    errEvent <= '0;
  endtask : send

  // random report aimed at bank index b
  function automatic errEvent_s mk(input logic [2:0] b, input errCause_e c);
    errEvent_s e;
    e.valid      = 1'b1;
    e.ctrlSel    = b[2];  // upper half belongs to the second controller
    e.bankInCtrl = b[1:0];
    e.cause      = c;
    e.txnType    = 3'($urandom());
    e.channel    = 4'($urandom());
    e.deviceCode = 5'($urandom());
    e.bitMask    = 16'($urandom());
    e.rank       = 5'($urandom());
    e.bufferId   = 5'($urandom());
    return e;
  endfunction : mk

  // watcher: every ack consumes the oldest note
  always @(posedge clk_sys) begin
    if (wbAck === 1'b1) begin
      if (notes.size() == 0) begin
        check("unrequested ack", 32'h1, 32'h0);
      end else begin
        mon = notes.pop_front();
        if (mon.chk) check(mon.nm, wbDatOut, mon.exp);
      end
    end
  end

  // main sequence
  initial begin
    logic [15:0] codes[9];    // model-specific code per cause, enum order
    errCause_e   causeTab[8]; // one non-read cause per bank
    errEvent_s   sent[8];     // what each bank was given
    errEvent_s   e1;
    errEvent_s   e2;
    errEvent_s   e3;
    logic [7:0]  base;
    logic [31:0] det;
    int          i;
    void'($urandom(19));
    codes = '{MSC_ADDR_PARITY, MSC_HA_WR_DATA_PAR, MSC_HA_WR_BE_PAR, MSC_SCRUB_CORR,
              MSC_SCRUB_UNCORR, MSC_SPARE_CORR, MSC_SPARE_UNCORR, MSC_READ_CORR,
              MSC_BUFFER_PARITY};
    causeTab = '{CAUSE_ADDR_PARITY, CAUSE_HOME_AGENT_WR_DATA, CAUSE_HOME_AGENT_WR_BE,
                 CAUSE_SCRUB_CORR, CAUSE_SCRUB_UNCORR, CAUSE_SPARE_CORR,
                 CAUSE_SPARE_UNCORR, CAUSE_BUFFER_PARITY};
    n_fail = 0;
    n_tests = 0;
    rst_n = 1'b0;
    errEvent = '0;
    wbReq = '0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    // reset values and an unmapped place
    rd(CTRL_OFS, "control reset", 32'h0000_0000);
    rd(IRQ_MASK_OFS, "mask reset", 32'h0000_0000);
    wr(8'h90, 32'hFFFF_FFFF);
    rd(8'h90, "unmapped", 32'h0000_0000);
    // every non-read cause into its own bank, extra logging off
    for (i = 0; i < 8; i++) begin
      sent[i] = mk(3'(i), causeTab[i]);
      send(sent[i]);
    end
    for (i = 0; i < 8; i++) begin
      base = BANK_SPAN_OFS * 8'(i);
      det = 32'h0000_0000;
      if (causeTab[i] inside {CAUSE_HOME_AGENT_WR_DATA, CAUSE_HOME_AGENT_WR_BE,
                              CAUSE_BUFFER_PARITY}) det = 32'(sent[i].bufferId) << DET_BUF_LSB;
      rd(base, "status lo", {codes[causeTab[i]], ARCH_MEM_MARK |
         16'({sent[i].txnType, sent[i].channel})});
      rd(base + 8'h04, "status hi off", 32'h0000_0000);
      rd(base + 8'h08, "detail lo", det);
      rd(base + 8'h0C, "detail hi off", 32'h0000_0000);
    end
    // interrupt: raised, masked, unmasked, cleared
    rd(IRQ_STATUS_OFS, "irq status", 32'h0000_00FF);
    @(negedge clk_sys);
    check("irq masked", 32'(irq), 32'h0);
    wr(IRQ_MASK_OFS, 32'h0000_0008);
    @(negedge clk_sys);
    check("irq unmasked", 32'(irq), 32'h1);
    wr(IRQ_STATUS_OFS, 32'h0000_0008);
    @(negedge clk_sys);
    check("irq cleared", 32'(irq), 32'h0);
    rd(IRQ_STATUS_OFS, "irq status w1c", 32'h0000_00F7);
    // empty all banks and pending bits
    for (i = 0; i < 8; i++) wr(BANK_SPAN_OFS * 8'(i), 32'h0000_0000);
    wr(IRQ_STATUS_OFS, 32'h0000_00FF);
    // corrected read is not logged while extra logging is off
    send(mk(3'h0, CAUSE_READ_CORR));
    rd(8'h00, "read dropped", 32'h0000_0000);
    rd(IRQ_STATUS_OFS, "read no irq", 32'h0000_0000);
    // extra logging on: first, second and an ignored third corrected read
    wr(CTRL_OFS, 32'h0000_0002);
    rd(CTRL_OFS, "control on", 32'h0000_0002);
    e1 = mk(3'h0, CAUSE_READ_CORR);
    e2 = mk(3'h0, CAUSE_READ_CORR);
    e3 = mk(3'h0, CAUSE_READ_CORR);
    send(e1);
    send(e2);
    send(e3);
    rd(8'h00, "read status lo", {MSC_READ_CORR, ARCH_MEM_MARK |
       16'({e1.txnType, e1.channel})});
    rd(8'h04, "status hi dev", {27'h0, e1.deviceCode});
    rd(8'h08, "detail lo dev", {e2.bitMask[1:0], e1.bitMask, e2.deviceCode, 9'h000});
    rd(8'h0C, "detail hi dev", {2'h3, 6'h00, e2.rank, e1.rank,
       e2.bitMask[15:2]});
    // extra fields in status hi and detail hi vanish once logging is turned off again
    wr(CTRL_OFS, 32'h0000_0000);
    rd(8'h04, "status hi cleared", 32'h0000_0000);
    rd(8'h0C, "detail hi cleared", 32'h0000_0000);
    // mid-run reset empties banks and pending bits
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(8'h00, "status lo after reset", 32'h0000_0000);
    rd(IRQ_STATUS_OFS, "irq status after reset", 32'h0000_0000);
    // let the watcher take the last answer before the verdict
    @(negedge clk_sys);
    tally_and_finish();
  end
endmodule : memory_ctrl_error_logging_tb_top
